// ==== line_state_pkg.sv ====
// constants and types shared by the line state monitor and its pair classifier
package line_state_pkg;

   // ----------------------------------------------------------------------
   // symbol codes on the receive symbol path (5 bits per symbol)
   // ----------------------------------------------------------------------
   localparam int SYM_W = 5;
   localparam int PAIR_W = 10;
   localparam logic [4:0] SYM_QUIET = 5'h00;
   localparam logic [4:0] SYM_IDLE = 5'h1F;
   localparam logic [4:0] SYM_HALT = 5'h04;
   localparam logic [4:0] SYM_J = 5'h18;
   localparam logic [4:0] SYM_K = 5'h11;

   // ----------------------------------------------------------------------
   // line state encodings of the current line state field
   // ----------------------------------------------------------------------
   localparam logic [2:0] LS_NOISE = 3'h0;
   localparam logic [2:0] LS_ACTIVE = 3'h1;
   localparam logic [2:0] LS_UNDEFINED = 3'h2;
   localparam logic [2:0] LS_IDLE_SHORT = 3'h3;
   localparam logic [2:0] LS_QUIET = 3'h4;
   localparam logic [2:0] LS_MASTER = 3'h5;
   localparam logic [2:0] LS_HALT = 3'h6;
   localparam logic [2:0] LS_IDLE_LONG = 3'h7;
   localparam logic [2:0] LS_RESET = LS_NOISE;

   // ----------------------------------------------------------------------
   // pair counter thresholds
   // ----------------------------------------------------------------------
   localparam logic [2:0] CNT_FULL = 3'h7;
   localparam logic [2:0] CNT_IDLE_SHORT = 3'h1;

   // ----------------------------------------------------------------------
   // status register field positions
   // ----------------------------------------------------------------------
   localparam int ST_LINE_LSB = 5;
   localparam int ST_LINE_MSB = 7;
   localparam int ST_STATE_BIT = 4;
   localparam int ST_UNKNOWN_BIT = 3;
   localparam int ST_CNT_LSB = 0;
   localparam int ST_CNT_MSB = 2;
   localparam int STATUS_W = 16;

   // ----------------------------------------------------------------------
   // register map (byte addresses) and interrupt bits
   // ----------------------------------------------------------------------
   localparam logic [7:0] ADDR_STATUS_A = 8'h00;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h04;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h08;
   localparam int IRQ_W = 2;
   localparam int IRQ_CHANGE_BIT = 0;
   localparam int IRQ_UNKNOWN_BIT = 1;
   localparam logic [1:0] IRQ_MASK_RESET = 2'h0;

   // ----------------------------------------------------------------------
   // enumerations
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      PAIR_NOISE,
      PAIR_ACTIVE,
      PAIR_IDLE,
      PAIR_QUIET,
      PAIR_MASTER,
      PAIR_HALT
   } pair_kind_t;

   typedef enum logic {
      RECOG_KNOWN,
      RECOG_SEEKING
   } recog_state_t;

endpackage

// ==== line_pair_classifier.sv ====
// sorts each received symbol pair into the kind of line state it supports
`timescale 1ns/1ps
module line_pair_classifier
(
   input wire logic [line_state_pkg::PAIR_W-1:0] pair,
   output line_state_pkg::pair_kind_t kind
);
   import line_state_pkg::*;

   logic [4:0] sym_hi;
   logic [4:0] sym_lo;

   assign sym_hi = pair[9:5];
   assign sym_lo = pair[4:0];

   // ----------------------------------------------------------------------
   // classification
   // ----------------------------------------------------------------------
   // master line state alternates halt and quiet, so either order counts;
   // a start delimiter or any other pair with no quiet or halt symbol, save a pair of two idle symbols, is taken as active traffic
   always_comb
   begin
      if (sym_hi == SYM_QUIET && sym_lo == SYM_QUIET)
         kind = PAIR_QUIET;
      else if (sym_hi == SYM_IDLE && sym_lo == SYM_IDLE)
         kind = PAIR_IDLE;
      else if (sym_hi == SYM_HALT && sym_lo == SYM_HALT)
         kind = PAIR_HALT;
      else if ((sym_hi == SYM_HALT && sym_lo == SYM_QUIET) ||
               (sym_hi == SYM_QUIET && sym_lo == SYM_HALT))
         kind = PAIR_MASTER;
      else if (sym_hi == SYM_J && sym_lo == SYM_K)
         kind = PAIR_ACTIVE;
      else if (sym_hi == SYM_QUIET || sym_lo == SYM_QUIET ||
               sym_hi == SYM_HALT || sym_lo == SYM_HALT)
         kind = PAIR_NOISE; // broken control patterns are noise
      else
         kind = PAIR_ACTIVE;
   end

endmodule

// ==== line_state_monitor.sv ====
// line state recogniser with AHB-Lite status, interrupt status and mask registers
//
// Overview of operation
// - line state codes: noise, active, undefined, idle short, quiet, master, halt, idle long
// - status bit 4 shows the recogniser's single state bit
// - sixteen symbols are needed for a new line state, four for short idle
// - status bit 3 is one while seeking a new state, zero once known
// - status bits 2..0 show the like symbol pair counter
// - at count seven the new state is loaded and the unknown flag cleared
// - short idle is declared after two consecutive idle pairs
// - status bits 7..5 hold the most recently recognised line state
//
// The placing of the registers and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
module line_state_monitor
(
   input wire logic CLK,
   input wire logic RST,
   input wire logic [line_state_pkg::PAIR_W-1:0] RX_PAIR,
   input wire logic RX_PAIR_VALID,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   output logic IRQ
);
   import line_state_pkg::*;

   // ----------------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------------
   pair_kind_t kind;
   pair_kind_t prev_kind_q;
   logic have_prev_q;
   logic [2:0] pair_cnt_q;
   logic [2:0] line_state_q;
   logic unknown_q;
   recog_state_t recog_q;
   recog_state_t recog_d;
   logic pair_break;
   logic change_evt;
   logic unknown_evt;
   logic [2:0] cnt_next;
   logic load_state;
   logic [2:0] new_state;
   logic [STATUS_W-1:0] status_a;
   logic [IRQ_W-1:0] irq_status_q;
   logic [IRQ_W-1:0] irq_status_d;
   logic [IRQ_W-1:0] irq_mask_q;
   logic [IRQ_W-1:0] irq_set;
   logic [IRQ_W-1:0] irq_clr;
   logic addr_phase;
   logic wr_pend_q;
   logic [7:0] wr_addr_q;

   // maps a pair kind onto the line state it leads to after a full run
   function automatic logic [2:0] state_of(input pair_kind_t k);
      case (k)
         PAIR_ACTIVE: state_of = LS_ACTIVE;
         PAIR_IDLE: state_of = LS_IDLE_LONG;
         PAIR_QUIET: state_of = LS_QUIET;
         PAIR_MASTER: state_of = LS_MASTER;
         PAIR_HALT: state_of = LS_HALT;
         default: state_of = LS_NOISE;
      endcase
   endfunction

   // true when a byte address selects the given register word
   function automatic logic hits(input logic [31:0] a, input logic [7:0] reg_addr);
      hits = (a[31:8] == 24'h000000) && (a[7:2] == reg_addr[7:2]);
   endfunction

   // ----------------------------------------------------------------------
   // pair classification
   // ----------------------------------------------------------------------
   line_pair_classifier u_classifier
   (
      .pair(RX_PAIR),
      .kind(kind)
   );

   // ----------------------------------------------------------------------
   // recogniser next-state decode
   // ----------------------------------------------------------------------
   // a pair that breaks the run: the first after reset, or one of another kind
   assign pair_break = RX_PAIR_VALID && (!have_prev_q || kind != prev_kind_q);

   // the counter saturates at seven so a steady line never re-announces
   always_comb
   begin
      cnt_next = pair_cnt_q;
      load_state = 1'b0;
      new_state = line_state_q;
      if (RX_PAIR_VALID)
      begin
         if (pair_break)
            cnt_next = 3'h0;
         else if (pair_cnt_q != CNT_FULL)
            cnt_next = pair_cnt_q + 3'h1;
         if (!pair_break)
         begin
            // eight like pairs are sixteen symbols; idle needs only four
            if (cnt_next == CNT_FULL && pair_cnt_q != CNT_FULL)
            begin
               load_state = 1'b1;
               new_state = state_of(kind);
            end
            else if (kind == PAIR_IDLE && cnt_next == CNT_IDLE_SHORT)
            begin
               load_state = 1'b1;
               new_state = LS_IDLE_SHORT;
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // previous pair kind and pair counter
   // ----------------------------------------------------------------------
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         prev_kind_q <= PAIR_NOISE;
         have_prev_q <= 1'b0;
         pair_cnt_q <= 3'h0;
      end
      else if (RX_PAIR_VALID)
      begin
         prev_kind_q <= kind;
         have_prev_q <= 1'b1;
         pair_cnt_q <= cnt_next;
      end
   end

   // ----------------------------------------------------------------------
   // current line state and unknown flag
   // ----------------------------------------------------------------------
   // a state stays shown while the next one is sought, so software always
   // sees the last recognised state rather than a transient guess
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         line_state_q <= LS_RESET;
         unknown_q <= 1'b1;
      end
      else if (RX_PAIR_VALID)
      begin
         if (load_state)
         begin
            line_state_q <= new_state;
            unknown_q <= 1'b0;
         end
         else if (pair_break)
         begin
            unknown_q <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------------
   // recogniser state bit
   // ----------------------------------------------------------------------
   // a known state may still be refined: short idle grows into long idle
   // without any seeking in between, so only a break leaves known
   always_comb
   begin
      recog_d = recog_q;
      case (recog_q)
         RECOG_KNOWN:
         begin
            if (pair_break)
               recog_d = RECOG_SEEKING;
         end
         RECOG_SEEKING:
         begin
            if (load_state)
               recog_d = RECOG_KNOWN;
         end
         default:
         begin
            recog_d = RECOG_SEEKING;
         end
      endcase
   end

   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
         recog_q <= RECOG_SEEKING;
      else
         recog_q <= recog_d;
   end

   // events: a new state declared, or the line left a known state
   assign change_evt = RX_PAIR_VALID && load_state && (new_state != line_state_q);
   assign unknown_evt = pair_break && !unknown_q;

   // ----------------------------------------------------------------------
   // status word
   // ----------------------------------------------------------------------
   // upper bits belong to other functions of the device and read as zero
   always_comb
   begin
      status_a = '0;
      status_a[ST_LINE_MSB:ST_LINE_LSB] = line_state_q;
      status_a[ST_STATE_BIT] = (recog_q == RECOG_SEEKING);
      status_a[ST_UNKNOWN_BIT] = unknown_q;
      status_a[ST_CNT_MSB:ST_CNT_LSB] = pair_cnt_q;
   end

   // ----------------------------------------------------------------------
   // AHB-Lite address phase capture
   // ----------------------------------------------------------------------
   // no wait states: every transfer completes in its first data cycle
   assign addr_phase = HSEL && HTRANS[1] && HREADY;

   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
      end
      else
      begin
         wr_pend_q <= addr_phase && HWRITE;
         if (addr_phase)
            wr_addr_q <= HADDR[7:0];
      end
   end

   // read data is fetched at the address phase and stands in the data phase
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
         HRDATA <= 32'h00000000;
      else if (addr_phase && !HWRITE)
      begin
         if (hits(HADDR, ADDR_STATUS_A))
            HRDATA <= {16'h0000, status_a};
         else if (hits(HADDR, ADDR_IRQ_STATUS))
            HRDATA <= {30'h00000000, irq_status_q};
         else if (hits(HADDR, ADDR_IRQ_MASK))
            HRDATA <= {30'h00000000, irq_mask_q};
         else
            HRDATA <= 32'h00000000; // unmapped reads return zero
      end
   end

   // always ready and always OKAY; held in flops so outputs are registered
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         HREADYOUT <= 1'b1;
         HRESP <= 1'b0;
      end
      else
      begin
         HREADYOUT <= 1'b1;
         HRESP <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // interrupt status (write one to clear) and mask
   // ----------------------------------------------------------------------
   assign irq_set = {unknown_evt, change_evt};
   assign irq_clr = (wr_pend_q && hits({24'h000000, wr_addr_q}, ADDR_IRQ_STATUS)) ?
                    HWDATA[IRQ_W-1:0] : '0;

   // a set in the same cycle as its clear wins, so no event is lost
   assign irq_status_d = (irq_status_q & ~irq_clr) | irq_set;

   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
         irq_status_q <= '0;
      else
         irq_status_q <= irq_status_d;
   end

   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
         irq_mask_q <= IRQ_MASK_RESET;
      else if (wr_pend_q && hits({24'h000000, wr_addr_q}, ADDR_IRQ_MASK))
         irq_mask_q <= HWDATA[IRQ_W-1:0];
   end

   // one cycle behind the status flops; buys a clean registered output
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
         IRQ <= 1'b0;
      else
         IRQ <= |(irq_status_q & irq_mask_q);
   end

endmodule

// ==== line_state_monitor_properties.sv ====
// concurrent assertions on the line state monitor ports
`timescale 1ns/1ps
module line_state_monitor_properties
(
   input wire logic CLK,
   input wire logic RST,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   input wire logic [31:0] HRDATA,
   input wire logic HREADYOUT,
   input wire logic HRESP,
   input wire logic IRQ
);
   import line_state_pkg::*;
   // ----
   // data phase tracking
   // ----
   logic rd_q;
   logic wm_q;
   // flags the data phase of a status read or a mask write; zero wait states assumed
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         rd_q <= 1'b0;
         wm_q <= 1'b0;
      end
      else if (HREADY)
      begin
         rd_q <= HSEL && HTRANS[1] && !HWRITE && HADDR[7:0] == ADDR_STATUS_A;
         wm_q <= HSEL && HTRANS[1] && HWRITE && HADDR[7:0] == ADDR_IRQ_MASK;
      end
   end
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);
   // mask cleared, then the level output needs one more edge to follow
   sequence mask_off;
      wm_q && HWDATA[1:0] == 2'h0;
   endsequence
   sequence irq_low;
      ##1 !IRQ;
   endsequence
   AST_NO_UNDEFINED: assert property (rd_q |-> HRDATA[7:5] != LS_UNDEFINED)
      else $error("undefined line state code read");
   AST_STATE_BIT: assert property (rd_q |-> HRDATA[4] == HRDATA[3])
      else $error("state bit differs from unknown flag");
   AST_SEEK_COUNT: assert property (rd_q && HRDATA[3] |-> HRDATA[2:0] != CNT_FULL)
      else $error("seeking with a full pair count");
   AST_KNOWN_FULL: assert property (rd_q && !HRDATA[3] && HRDATA[7:5] != LS_IDLE_SHORT
      |-> HRDATA[2:0] == CNT_FULL)
      else $error("known state without eight like pairs");
   AST_SHORT_IDLE: assert property (rd_q && !HRDATA[3] && HRDATA[7:5] == LS_IDLE_SHORT
      |-> HRDATA[2:0] inside {[3'h1:3'h6]})
      else $error("short idle with wrong pair count");
   AST_RESET_CLEAR: assert property ($fell(RST) |-> HRDATA == 32'h0 && !IRQ)
      else $error("outputs not cleared by reset");
   AST_BUS_OKAY: assert property (HREADYOUT && !HRESP)
      else $error("wait state or error response");
   AST_MASK_OFF: assert property (mask_off |=> irq_low)
      else $error("interrupt still high after mask cleared");
endmodule
bind line_state_monitor line_state_monitor_properties chk
(
   .CLK(CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
   .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
   .HRESP(HRESP), .IRQ(IRQ)
);

// ==== line_pair_source.sv ====
// upstream receive symbol path model handing over symbol pairs
`timescale 1ns/1ps
module line_pair_source
(
   input wire logic clk,
   output logic [line_state_pkg::PAIR_W-1:0] pair,
   output logic valid
);
   import line_state_pkg::*;
   initial
   begin
      pair = 10'h155;
      valid = 1'b0;
   end
   // n pairs, gap dead cycles after each; between pairs the bus shows the inverse
   task automatic send(input logic [PAIR_W-1:0] p, input int n, input int gap);
      for (int i = 0; i < n; i++)
      begin
         @(posedge clk);
         pair <= p;
         valid <= 1'b1;
         if (gap > 0)
         begin
            @(posedge clk);
            valid <= 1'b0;
            pair <= ~p;
            repeat (gap - 1) @(posedge clk);
         end
      end
      @(posedge clk);
      valid <= 1'b0;
      pair <= ~p;
   endtask
endmodule

// ==== line_state_monitor_tb.sv ====
// self-checking testbench for the line state monitor
`timescale 1ns/1ps
module line_state_monitor_tb;
   import line_state_pkg::*;
   localparam logic [9:0] P_IDLE = {SYM_IDLE, SYM_IDLE};
   localparam logic [9:0] P_QUIET = {SYM_QUIET, SYM_QUIET};
   localparam logic [39:0] KP = {SYM_QUIET, SYM_J, SYM_J, SYM_K, SYM_HALT, SYM_QUIET,
      SYM_HALT, SYM_HALT};
   localparam logic [11:0] KC = {LS_NOISE, LS_ACTIVE, LS_MASTER, LS_HALT};
   logic clk;
   logic rst;
   logic hsel;
   logic hwrite;
   logic [1:0] htrans;
   logic [31:0] haddr;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic irq;
   logic [PAIR_W-1:0] pair;
   logic pair_valid;
   logic [31:0] rd;
   logic [2:0] prev;
   int fail_count = 0;
   int total_checks = 0;
   line_state_monitor uut
   (
      .CLK(clk), .RST(rst), .RX_PAIR(pair), .RX_PAIR_VALID(pair_valid), .HSEL(hsel),
      .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
      .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .IRQ(irq)
   );
   line_pair_source src (.clk(clk), .pair(pair), .valid(pair_valid));
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // ----
   // bus and compare helpers
   // ----
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // one single transfer; waits on the ready line rather than assuming zero wait states
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= wr;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      rd = hrdata;
   endtask
   task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(what, rd, exp);
   endtask
   function automatic logic [31:0] st(input logic [2:0] ls, input logic u, input logic [2:0] c);
      return {24'h0, ls, u, u, c};
   endfunction
   // irq is registered one edge behind the mask and status registers
   task automatic chk_irq(input logic exp);
      repeat (3) @(posedge clk);
      #1;
      chk("irq", {31'h0, irq}, {31'h0, exp});
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // hang guard, far beyond the few hundred cycles the sequence needs
   initial
   begin
      #100000;
      fail_count++;
      summarize();
   end
   // ----
   // main sequence
   // ----
   initial
   begin
      rst = 1'b1;
      hsel = 1'b0;
      htrans = 2'h0;
      haddr = 32'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      rdc("status", ADDR_STATUS_A, st(LS_RESET, 1'b1, 3'h0));
      rdc("irq status", ADDR_IRQ_STATUS, 32'h0);
      rdc("unmapped", 8'h0C, 32'h0);
      src.send(P_IDLE, 1, 0);
      rdc("status", ADDR_STATUS_A, st(LS_RESET, 1'b1, 3'h0));
      src.send(P_IDLE, 1, 2);
      rdc("status", ADDR_STATUS_A, st(LS_IDLE_SHORT, 1'b0, 3'h1));
      src.send(P_IDLE, 5, 0);
      rdc("status", ADDR_STATUS_A, st(LS_IDLE_SHORT, 1'b0, 3'h6));
      src.send(P_IDLE, 2, 1);
      rdc("status", ADDR_STATUS_A, st(LS_IDLE_LONG, 1'b0, 3'h7));
      src.send(P_QUIET, 1, 0);
      rdc("status", ADDR_STATUS_A, st(LS_IDLE_LONG, 1'b1, 3'h0));
      src.send(P_QUIET, 7, 0);
      rdc("status", ADDR_STATUS_A, st(LS_QUIET, 1'b0, 3'h7));
      prev = LS_QUIET;
      // halt, master, active, noise with growing gaps between pairs
      for (int k = 0; k < 4; k++)
      begin
         src.send(KP[k*10 +: 10], 7, k);
         rdc("status", ADDR_STATUS_A, st(prev, 1'b1, 3'h6));
         src.send(KP[k*10 +: 10], 1, 0);
         prev = KC[k*3 +: 3];
         rdc("status", ADDR_STATUS_A, st(prev, 1'b0, 3'h7));
      end
      bus(1'b1, ADDR_STATUS_A, 32'hFF);
      bus(1'b1, 8'h10, 32'hFF);
      rdc("status", ADDR_STATUS_A, st(LS_NOISE, 1'b0, 3'h7));
      rdc("irq status", ADDR_IRQ_STATUS, 32'h3);
      chk_irq(1'b0);
      bus(1'b1, ADDR_IRQ_MASK, 32'h3);
      chk_irq(1'b1);
      bus(1'b1, ADDR_IRQ_STATUS, 32'h1);
      rdc("irq status", ADDR_IRQ_STATUS, 32'h2);
      bus(1'b1, ADDR_IRQ_STATUS, 32'h2);
      rdc("irq status", ADDR_IRQ_STATUS, 32'h0);
      chk_irq(1'b0);
      bus(1'b1, ADDR_IRQ_MASK, 32'h2);
      src.send(P_IDLE, 1, 0);
      rdc("irq status", ADDR_IRQ_STATUS, 32'h2);
      chk_irq(1'b1);
      rdc("irq mask", ADDR_IRQ_MASK, 32'h2);
      bus(1'b1, ADDR_IRQ_MASK, 32'h0);
      chk_irq(1'b0);
      // reset in mid count must drop all state
      src.send(KP[0 +: 10], 3, 0);
      @(posedge clk);
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      rdc("status", ADDR_STATUS_A, st(LS_RESET, 1'b1, 3'h0));
      rdc("irq status", ADDR_IRQ_STATUS, 32'h0);
      summarize();
   end
endmodule
